// ### dcm_ctrl.sv
// Dual clock source selection and operating mode controller with AHB-Lite registers
`timescale 1ns/1ps
`include "dcm_cfg.svh"

module dcm_ctrl (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Register bus
    input wire dcm_pkg::dcm_ahb_req_s ahb_req,
    output dcm_pkg::dcm_ahb_rsp_s ahb_rsp,
    // Oscillator clocks and events, asynchronous to hclk
    input wire logic fast_clock,
    input wire logic slow_clock,
    input wire logic sleep_req,
    input wire logic wake_req,
    // Clock outputs
    output logic system_clock,
    output logic instruction_clock,
    output logic timer0_clock,
    // Oscillator and pad control
    output dcm_pkg::dcm_osc_ctl_s osc_ctl,
    output dcm_pkg::dcm_mode_e mode
);
    import dcm_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0] oscillator_control; // Control register
    logic [9:0] config_word; // Fixed configuration word
    logic cfg_locked; // Configuration frozen after first write
    logic start_pending; // Startup select to load
    logic ph_sel; // Data phase active
    logic ph_write; // Data phase is a write
    logic [7:0] ph_addr; // Address captured in address phase
    logic [1:0] fast_sync; // Fast clock synchroniser
    logic [1:0] slow_sync; // Slow clock synchroniser
    logic [1:0] sleep_sync; // Sleep input synchroniser
    logic [1:0] wake_sync; // Wake input synchroniser
    logic fast_d; // Previous synced fast level
    logic slow_d; // Previous synced slow level
    logic sleep_d; // Previous synced sleep level
    logic src_fast; // Source currently driving system clock
    logic gate_on; // System clock gate
    dcm_sw_e sw_state; // Switch state
    logic [1:0] settle_cnt; // Settle counter
    logic sys_d; // Previous system clock level
    logic [1:0] inst_div; // Instruction clock divider
    logic sys_rise; // System clock rising edge
    logic cur_level; // Level of selected source
    logic want_fast; // Requested source
    logic acc_ok; // Valid address phase
    logic wr_ctrl; // Control write strobe
    logic [31:0] next_rdata; // Read mux
    logic [31:0] rdata_q; // Registered read data
    logic run_gate; // Halt gate, moves only while the source is low

    // ------------------------------------------------------------------------
    // Synchronisers: first stage feeds only the second
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fast_sync <= 2'h0;
            slow_sync <= 2'h0;
            sleep_sync <= 2'h0;
            wake_sync <= 2'h0;
        end
        else if (clk_en)
        begin
            fast_sync <= {fast_sync[0], fast_clock};
            slow_sync <= {slow_sync[0], slow_clock};
            sleep_sync <= {sleep_sync[0], sleep_req};
            wake_sync <= {wake_sync[0], wake_req};
        end
    end

    // ------------------------------------------------------------------------
    // AHB-Lite slave: zero wait, always OKAY
    // ------------------------------------------------------------------------
    assign acc_ok = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    assign wr_ctrl = ph_sel && ph_write && (ph_addr == `DCM_OSC_CTRL_ADDR);

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_sel <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (clk_en)
        begin
            ph_sel <= acc_ok;
            ph_write <= ahb_req.hwrite;
            ph_addr <= ahb_req.haddr[7:0];
        end
    end

    // Read mux; unmapped reads return zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (ahb_req.haddr[7:0])
            `DCM_OSC_CTRL_ADDR: next_rdata = {24'h00_0000, oscillator_control};
            `DCM_CONFIG_ADDR: next_rdata = {21'h00_0000, cfg_locked, config_word};
            `DCM_STATUS_ADDR: next_rdata = {27'h000_0000, sw_state != dcm_sw_idle,
                src_fast, 1'b0, mode};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else if (clk_en && acc_ok && !ahb_req.hwrite)
            rdata_q <= next_rdata;
    end
    // One driver for the whole answer: zero wait, always OKAY
    assign ahb_rsp = {rdata_q, 1'b1, 1'b0};

    // ------------------------------------------------------------------------
    // Configuration word, writable once until the next reset
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            config_word <= `DCM_CFG_RESET;
            cfg_locked <= 1'b0;
        end
        else if (clk_en && ph_sel && ph_write && !cfg_locked
            && ph_addr == `DCM_CONFIG_ADDR)
        begin
            config_word <= ahb_req.hwdata[9:0];
            cfg_locked <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Control register and operating mode
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            oscillator_control <= 8'h00;
            start_pending <= 1'b1;
            mode <= dcm_normal;
            sleep_d <= 1'b0;
        end
        else if (clk_en)
        begin
            sleep_d <= sleep_sync[1];
            if (start_pending)
            begin
                oscillator_control <= {7'h00, config_word[`DCM_CFG_START_FAST_BIT]};
                start_pending <= 1'b0;
                mode <= config_word[`DCM_CFG_START_FAST_BIT] ? dcm_normal : dcm_slow;
            end
            else if (mode == dcm_standby || mode == dcm_halt)
            begin
                // Wake returns to the mode given by the select bit
                if (wake_sync[1])
                begin
                    oscillator_control[`DCM_PMODE_MSB:`DCM_PMODE_LSB] <= `DCM_PMODE_RUN;
                    mode <= oscillator_control[`DCM_SEL_BIT] ? dcm_normal : dcm_slow;
                end
            end
            else if (wr_ctrl)
            begin
                oscillator_control <= {3'h0, ahb_req.hwdata[4:0]};
                // mode field requests a low power mode
                if (ahb_req.hwdata[`DCM_PMODE_MSB:`DCM_PMODE_LSB] == `DCM_PMODE_STANDBY)
                    mode <= dcm_standby;
                else if (ahb_req.hwdata[`DCM_PMODE_MSB:`DCM_PMODE_LSB] == `DCM_PMODE_HALT)
                    mode <= dcm_halt;
                else
                    mode <= ahb_req.hwdata[`DCM_SEL_BIT] ? dcm_normal : dcm_slow;
            end
            else if (sleep_sync[1] && !sleep_d)
                mode <= dcm_halt;
        end
    end

    // ------------------------------------------------------------------------
    // Glitch-free source switch: gate off and swap, settle, gate on
    // ------------------------------------------------------------------------
    assign want_fast = oscillator_control[`DCM_SEL_BIT];
    assign cur_level = src_fast ? fast_sync[1] : slow_sync[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sw_state <= dcm_sw_idle;
            src_fast <= 1'b1;
            gate_on <= 1'b1;
            settle_cnt <= 2'h0;
        end
        else if (clk_en)
        begin
            case (sw_state)
                dcm_sw_idle:
                    if (want_fast != src_fast)
                        sw_state <= dcm_sw_gate_old;
                dcm_sw_gate_old:
                    // Stop only while the old source is low
                    if (!cur_level)
                    begin
                        gate_on <= 1'b0;
                        src_fast <= want_fast;
                        settle_cnt <= 2'(`DCM_SWITCH_SETTLE_CYC);
                        sw_state <= dcm_sw_wait;
                    end
                dcm_sw_wait:
                    if (settle_cnt == 2'h0)
                        sw_state <= dcm_sw_gate_new;
                    else
                        settle_cnt <= settle_cnt - 2'h1;
                dcm_sw_gate_new:
                    // Resume only while the new source is low
                    if (!cur_level)
                    begin
                        gate_on <= 1'b1;
                        sw_state <= dcm_sw_idle;
                    end
                default:
                    sw_state <= dcm_sw_idle;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Clock outputs rebuilt in the hclk domain
    // ------------------------------------------------------------------------
    assign sys_rise = system_clock && !sys_d;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            system_clock <= 1'b0;
            run_gate <= 1'b1;
            sys_d <= 1'b0;
            timer0_clock <= 1'b0;
            fast_d <= 1'b0;
            slow_d <= 1'b0;
        end
        else if (clk_en)
        begin
            fast_d <= fast_sync[1];
            slow_d <= slow_sync[1];
            sys_d <= system_clock;
            // Halt gates the clock only in a low phase, so no runt pulse
            if (!cur_level)
                run_gate <= (mode != dcm_halt);
            system_clock <= gate_on && run_gate && cur_level;
            if (oscillator_control[`DCM_LCK_BIT] && config_word[`DCM_CFG_T0SRC_BIT])
                timer0_clock <= slow_sync[1];
            else
                timer0_clock <= system_clock;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            inst_div <= 2'h0;
            instruction_clock <= 1'b0;
        end
        else if (clk_en && sys_rise)
        begin
            inst_div <= inst_div + 2'h1;
            if (config_word[`DCM_CFG_DIV4_BIT])
                instruction_clock <= inst_div[1];
            else
                instruction_clock <= inst_div[0];
        end
    end

    // ------------------------------------------------------------------------
    // Oscillator enables and pad ownership
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            osc_ctl <= '0;
        else if (clk_en)
        begin
            // fast stops in Halt, or by stop bit while slow is both the source and the selection
            osc_ctl.fast_osc_en <= (mode != dcm_halt) && !(oscillator_control[`DCM_STOP_BIT]
                && !src_fast && !want_fast);
            osc_ctl.slow_osc_en <= (mode != dcm_halt);
            osc_ctl.fast_src <= config_word[`DCM_CFG_FSRC_MSB:`DCM_CFG_FSRC_LSB];
            osc_ctl.rc_freq <= config_word[`DCM_CFG_RCF_MSB:`DCM_CFG_RCF_LSB];
            osc_ctl.slow_src <= config_word[`DCM_CFG_SSRC_BIT];
            osc_ctl.pad_xtal <= (config_word[`DCM_CFG_FSRC_MSB:`DCM_CFG_FSRC_LSB]
                != `DCM_FSRC_IRC) || config_word[`DCM_CFG_SSRC_BIT];
            osc_ctl.pad_clk_out <= (config_word[`DCM_CFG_FSRC_MSB:`DCM_CFG_FSRC_LSB]
                == `DCM_FSRC_IRC) && !config_word[`DCM_CFG_SSRC_BIT]
                && config_word[`DCM_CFG_CKOUT_BIT];
        end
    end

endmodule // dcm_ctrl

// ### dcm_cfg.svh
// Constants for the dual clock mode controller: offsets, fields, reset values, timing
`ifndef DCM_CFG_SVH
`define DCM_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define DCM_OSC_CTRL_ADDR 8'h00
`define DCM_CONFIG_ADDR 8'h04
`define DCM_STATUS_ADDR 8'h08

// ----------------------------------------------------------------------------
// Oscillator control fields
// ----------------------------------------------------------------------------
`define DCM_SEL_BIT 0
`define DCM_STOP_BIT 1
`define DCM_PMODE_LSB 2
`define DCM_PMODE_MSB 3
`define DCM_LCK_BIT 4

// ----------------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------------
`define DCM_CFG_FSRC_LSB 0
`define DCM_CFG_FSRC_MSB 1
`define DCM_CFG_RCF_LSB 2
`define DCM_CFG_RCF_MSB 4
`define DCM_CFG_SSRC_BIT 5
`define DCM_CFG_DIV4_BIT 6
`define DCM_CFG_START_FAST_BIT 7
`define DCM_CFG_T0SRC_BIT 8
`define DCM_CFG_CKOUT_BIT 9
`define DCM_CFG_RESET 10'h081

// ----------------------------------------------------------------------------
// Power mode requests and fast source codes
// ----------------------------------------------------------------------------
`define DCM_PMODE_RUN 2'h0
`define DCM_PMODE_HALT 2'h1
`define DCM_PMODE_STANDBY 2'h2
`define DCM_FSRC_IRC 2'h0
`define DCM_FSRC_HXT 2'h1
`define DCM_FSRC_XT 2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DCM_CLK_PERIOD_NS 50
`define DCM_SWITCH_SETTLE_NS 100
`define DCM_SWITCH_SETTLE_CYC ((`DCM_SWITCH_SETTLE_NS + `DCM_CLK_PERIOD_NS - 1) / `DCM_CLK_PERIOD_NS)

`endif

// ### dcm_pkg.sv
// Types for the dual clock mode controller
package dcm_pkg;

    // Operating modes
    typedef enum logic [1:0] {dcm_normal, dcm_slow, dcm_standby, dcm_halt} dcm_mode_e;

    // Glitch-free switch states
    typedef enum logic [2:0] {
        dcm_sw_idle, dcm_sw_gate_old, dcm_sw_wait, dcm_sw_gate_new
    } dcm_sw_e;

    // AHB-Lite request from the master
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } dcm_ahb_req_s;

    // AHB-Lite answer from the slave
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } dcm_ahb_rsp_s;

    // Oscillator and pad controls
    typedef struct packed {
        logic fast_osc_en;
        logic slow_osc_en;
        logic [1:0] fast_src;
        logic [2:0] rc_freq;
        logic slow_src;
        logic pad_xtal;
        logic pad_clk_out;
    } dcm_osc_ctl_s;

endpackage

// ### dcm_ctrl_asserts.sv
// Concurrent checks on the ports of the dual clock mode controller
`timescale 1ns/1ps
`include "dcm_cfg.svh"

module dcm_ctrl_asserts
    import dcm_pkg::*;
(
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Register bus
    input wire dcm_pkg::dcm_ahb_req_s ahb_req,
    input wire dcm_pkg::dcm_ahb_rsp_s ahb_rsp,
    // Oscillators and events
    input wire logic fast_clock,
    input wire logic slow_clock,
    input wire logic sleep_req,
    input wire logic wake_req,
    // Watched outputs
    input wire logic system_clock,
    input wire logic instruction_clock,
    input wire logic timer0_clock,
    input wire dcm_pkg::dcm_osc_ctl_s osc_ctl,
    input wire dcm_pkg::dcm_mode_e mode
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic [1:0] age; // Cycles since reset, saturating
    logic ctl_wr; // Control write now in its data phase
    dcm_mode_e mode_d; // Mode one cycle ago
    logic [6:0] mode_age; // Cycles since the last mode change, saturating
    wire settled = (mode_age == 7'h7f);
    wire alive = (age == 2'h3);
    wire run = (mode == dcm_normal) || (mode == dcm_slow);
    // Age counter and write tracker; skips the edges right after reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            age <= 2'h0;
            ctl_wr <= 1'b0;
            mode_d <= dcm_normal;
            mode_age <= 7'h00;
        end
        else
        begin
            age <= alive ? age : age + 2'h1;
            mode_d <= mode;
            // A source switch may take dozens of cycles after a mode change
            mode_age <= (mode != mode_d) ? 7'h00 : (settled ? mode_age : mode_age + 7'h01);
            ctl_wr <= ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
                && clk_en && (ahb_req.haddr[7:0] == `DCM_OSC_CTRL_ADDR);
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_sel_fast;
        (alive && settled && mode == dcm_normal && $stable(fast_clock))[*8]
            |-> system_clock == fast_clock;
    endproperty
    a_sel_fast: assert property (p_sel_fast) else $error("system clock not on fast");
    property p_sel_slow;
        (alive && settled && mode == dcm_slow && $stable(slow_clock))[*8]
            |-> system_clock == slow_clock;
    endproperty
    a_sel_slow: assert property (p_sel_slow) else $error("system clock not on slow");
    property p_div;
        $stable(system_clock)[*4] |-> $stable(instruction_clock);
    endproperty
    a_div: assert property (p_div) else $error("instruction clock moved alone");
    property p_to_slow;
        ctl_wr && clk_en && !wake_req && ahb_req.hwdata[3:0] == 4'h0 && mode == dcm_normal
            |-> ##[1:12] mode == dcm_slow;
    endproperty
    a_to_slow: assert property (p_to_slow) else $error("slow mode not entered");
    property p_slow_run;
        (alive && mode == dcm_normal)[*2] |-> osc_ctl.slow_osc_en;
    endproperty
    a_slow_run: assert property (p_slow_run) else $error("slow osc off in normal");
    property p_pads;
        alive |-> osc_ctl.pad_xtal == (osc_ctl.fast_src != `DCM_FSRC_IRC || osc_ctl.slow_src);
    endproperty
    a_pads: assert property (p_pads) else $error("pad use wrong");
    property p_ckout;
        osc_ctl.pad_clk_out |-> !osc_ctl.pad_xtal && osc_ctl.fast_src == `DCM_FSRC_IRC;
    endproperty
    a_ckout: assert property (p_ckout) else $error("clock out on crystal pad");
    property p_standby;
        ctl_wr && clk_en && !wake_req && run && ahb_req.hwdata[3:2] == `DCM_PMODE_STANDBY
            |-> ##[1:2] mode == dcm_standby;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");
    property p_sleep;
        $rose(sleep_req) && run && !wake_req |-> ##[2:6] mode == dcm_halt;
    endproperty
    a_sleep: assert property (p_sleep) else $error("halt not entered");
    property p_glitch;
        $changed(system_clock) |=> $stable(system_clock)[*2];
    endproperty
    a_glitch: assert property (p_glitch) else $error("runt system clock phase");
    // Main scenarios reached
    c_slow: cover property (mode == dcm_slow);
    c_standby: cover property (mode == dcm_standby);
    c_halt: cover property (mode == dcm_halt);
    c_xtal: cover property (osc_ctl.pad_xtal);
endmodule // dcm_ctrl_asserts

bind dcm_ctrl dcm_ctrl_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .fast_clock(fast_clock), .slow_clock(slow_clock),
    .sleep_req(sleep_req), .wake_req(wake_req), .system_clock(system_clock),
    .instruction_clock(instruction_clock), .timer0_clock(timer0_clock),
    .osc_ctl(osc_ctl), .mode(mode));

// ### dcm_osc_model.sv
// Behavioural model of the fast and slow oscillator circuits
`timescale 1ns/1ps

module dcm_osc_model
    import dcm_pkg::*;
#(
    parameter int FAST_HALF_NS = 500, // Fast half period
    parameter int SLOW_HALF_NS = 2000 // Slow half period
)
(
    // Enables from the controller
    input wire dcm_pkg::dcm_osc_ctl_s osc_ctl,
    // Oscillator outputs
    output logic fast_clock,
    output logic slow_clock
);
    // fast runs while enabled
    // A stop lands only after a whole high phase; restart is offset from hclk
    always
    begin
        if (osc_ctl.fast_osc_en === 1'b1 || fast_clock === 1'b1)
        begin
            #(FAST_HALF_NS) fast_clock = ~fast_clock;
        end
        else
        begin
            fast_clock = 1'b0;
            @(osc_ctl);
            #3;
        end
    end
    always
    begin
        if (osc_ctl.slow_osc_en === 1'b1 || slow_clock === 1'b1)
        begin
            #(SLOW_HALF_NS) slow_clock = ~slow_clock;
        end
        else
        begin
            slow_clock = 1'b0;
            @(osc_ctl);
            #3;
        end
    end
endmodule // dcm_osc_model

// ### dcm_ctrl_test.sv
// Self-checking testbench for the dual clock mode controller
`timescale 1ns/1ps
`include "dcm_cfg.svh"

module dcm_ctrl_test;
    import dcm_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int FAST_HALF = 10; // Fast half period in hclk cycles
    localparam int SLOW_HALF = 40; // Slow half period in hclk cycles
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic sleep_req = 1'b0;
    logic wake_req = 1'b0;
    dcm_ahb_req_s ahb_req;
    dcm_ahb_rsp_s ahb_rsp;
    logic fast_clock, slow_clock, system_clock, instruction_clock, timer0_clock;
    dcm_osc_ctl_s osc_ctl;
    dcm_mode_e mode;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;
    integer seed = 32'hde4a3b6e;
    logic [31:0] rdat;
    logic [31:0] cfgw;
    // Bus request; hready is the slave's own hreadyout, word size
    assign ahb_req = {hsel, haddr, htrans, hwrite, 3'h2, ahb_rsp.hreadyout, hwdata};
    always #25 hclk = ~hclk;
    dcm_ctrl dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .ahb_req(ahb_req),
        .ahb_rsp(ahb_rsp), .fast_clock(fast_clock), .slow_clock(slow_clock),
        .sleep_req(sleep_req), .wake_req(wake_req), .system_clock(system_clock),
        .instruction_clock(instruction_clock), .timer0_clock(timer0_clock),
        .osc_ctl(osc_ctl), .mode(mode));
    dcm_osc_model #(.FAST_HALF_NS(FAST_HALF * 50), .SLOW_HALF_NS(SLOW_HALF * 50)) u_osc (
        .osc_ctl(osc_ctl), .fast_clock(fast_clock), .slow_clock(slow_clock));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic int exp_period(input logic div4);
        return (div4 ? 4 : 2) * 2 * FAST_HALF;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single transfer; an idle edge first so no signal is set twice
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        rdat = ahb_rsp.hrdata;
    endtask
    task automatic wait_mode(input dcm_mode_e m);
        int i;
        i = 0;
        while (mode !== m && i < 60)
        begin
            @(posedge hclk);
            i++;
        end
        chk({30'h0, mode}, {30'h0, m});
    endtask
    // Waits for a source edge, lets it settle, compares the chosen output
    task automatic follow(input logic tmr, input logic fast);
        logic v;
        int i;
        // Let any pending glitch-free switch finish first
        repeat (80) @(posedge hclk);
        v = fast ? fast_clock : slow_clock;
        i = 0;
        while ((fast ? fast_clock : slow_clock) === v && i < 100)
        begin
            @(posedge hclk);
            i++;
        end
        repeat (6) @(posedge hclk);
        chk({31'h0, tmr ? timer0_clock : system_clock}, {31'h0, fast ? fast_clock : slow_clock});
    endtask
    // Cycles until the next rising edge of the instruction clock
    task automatic inst_rise(output int k);
        k = 0;
        while (instruction_clock !== 1'b0 && k < 400)
        begin
            @(posedge hclk);
            k++;
        end
        while (instruction_clock !== 1'b1 && k < 400)
        begin
            @(posedge hclk);
            k++;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `DCM_OSC_CTRL_ADDR, 32'h0);
        chk(rdat & 32'h1f, 32'h1);
        chk({30'h0, mode}, {30'h0, dcm_normal});
        bus(1'b0, `DCM_CONFIG_ADDR, 32'h0);
        chk(rdat & 32'h3ff, {22'h0, `DCM_CFG_RESET});
        bus(1'b0, 8'h0c, 32'h0);
        chk(rdat, 32'h0);
        chk({31'h0, osc_ctl.slow_osc_en}, 32'h1);
        inst_rise(n);
        inst_rise(n);
        chk(n, exp_period(1'b0));
        follow(1'b0, 1'b1);
        cfgw = {22'h0, 4'hf, 1'b0, 3'($random(seed)), `DCM_FSRC_IRC};
        bus(1'b1, `DCM_CONFIG_ADDR, cfgw);
        bus(1'b1, `DCM_CONFIG_ADDR, {cfgw[31:2], `DCM_FSRC_HXT});
        repeat (4) @(posedge hclk);
        chk({29'h0, osc_ctl.rc_freq}, {29'h0, cfgw[4:2]});
        chk({30'h0, osc_ctl.pad_clk_out, osc_ctl.pad_xtal}, 32'h2);
        inst_rise(n);
        inst_rise(n);
        chk(n, exp_period(1'b1));
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h11);
        follow(1'b1, 1'b0);
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h0);
        wait_mode(dcm_slow);
        chk({31'h0, osc_ctl.fast_osc_en}, 32'h1);
        follow(1'b0, 1'b0);
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h2);
        repeat (4) @(posedge hclk);
        chk({31'h0, osc_ctl.fast_osc_en}, 32'h0);
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h1);
        wait_mode(dcm_normal);
        follow(1'b0, 1'b1);
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h9);
        wait_mode(dcm_standby);
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h0);
        wake_req <= 1'b1;
        wait_mode(dcm_normal);
        wake_req <= 1'b0;
        bus(1'b0, `DCM_OSC_CTRL_ADDR, 32'h0);
        chk(rdat & 32'hf, 32'h1);
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h5);
        wait_mode(dcm_halt);
        wake_req <= 1'b1;
        wait_mode(dcm_normal);
        wake_req <= 1'b0;
        repeat (4) @(posedge hclk);
        sleep_req <= 1'b1;
        wait_mode(dcm_halt);
        sleep_req <= 1'b0;
        wake_req <= 1'b1;
        wait_mode(dcm_normal);
        wake_req <= 1'b0;
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cfgw = {22'h0, 4'h2, 1'b1, 3'h0, 2'h1 + 2'($random(seed) & 1)};
        bus(1'b1, `DCM_CONFIG_ADDR, cfgw);
        repeat (4) @(posedge hclk);
        chk({30'h0, osc_ctl.fast_src}, {30'h0, cfgw[1:0]});
        chk({31'h0, osc_ctl.slow_src}, 32'h1);
        chk({30'h0, osc_ctl.pad_xtal, osc_ctl.pad_clk_out}, 32'h2);
        // A frozen block takes no control write
        clk_en <= 1'b0;
        bus(1'b1, `DCM_OSC_CTRL_ADDR, 32'h0);
        clk_en <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({30'h0, mode}, {30'h0, dcm_normal});
        end_sim();
    end
endmodule // dcm_ctrl_test
